// file: gauge_i2c_target.sv
// Behaviour
// - answer only target address 1010101, fixed
// - first byte 0xAA writes, 0xAB reads
// - five transfer types supported
// - quick read returns data at pointer
// - pointer advances on every acknowledged data byte
// - multi-byte write fills consecutive locations
// - write to read-only location gets NACK
// - command byte above 0x6B gets NACK
// - release both lines after 2 s low
// - line still held low: enter light sleep
// - at most two standard commands per second; later ones are still acked and only raise pace_violation
// - low-power modes stretch up to 100 us
// - normal modes stretch up to 4 ms
// - control location takes a two-byte subcommand
`timescale 1ns/10ps
`default_nettype none

module gauge_i2c_target #(
  parameter int unsigned BUS_TIMEOUT  = gauge_i2c_pkg::BUS_TIMEOUT_CYCLES,
  parameter int unsigned FLOW_STRETCH = gauge_i2c_pkg::FLOW_STRETCH_CYCLES,
  parameter int unsigned PACE_WINDOW  = gauge_i2c_pkg::PACE_WINDOW_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // serial clock pin
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  // serial data pin
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // command space access
  output logic      [7:0] cmd_ptr,
  input  wire logic [7:0] rd_data,
  output logic            wr_strobe,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  // power and pacing
  input  wire logic       flow_hold,
  input  wire logic       deep_low_power_mode,
  output logic            light_low_power,
  output logic            pace_violation
);

  import gauge_i2c_pkg::*;

  logic [1:0]    lvl;
  logic [1:0]    rise;
  logic [1:0]    fall;
  logic          scl_hi;
  logic          bus_timeout;
  logic          start_det;
  logic          stop_det;
  logic          low_power;

  target_state_t state_reg;
  target_state_t state_next;
  logic [3:0]    bit_cnt_reg;
  logic [3:0]    bit_cnt_next;
  logic [7:0]    shift_reg;
  logic [7:0]    shift_next;
  logic [7:0]    ptr_reg;
  logic [7:0]    ptr_next;
  logic          acked_reg;
  logic          acked_next;
  logic          sda_drv_reg;
  logic          sda_drv_next;
  logic          scl_drv_reg;
  logic          scl_drv_next;
  logic          wake_reg;
  logic          wake_next;
  logic [31:0]   stretch_cnt_reg;
  logic [31:0]   stretch_cnt_next;
  logic          wr_strobe_reg;
  logic          wr_strobe_next;
  logic [7:0]    wr_addr_reg;
  logic [7:0]    wr_addr_next;
  logic [7:0]    wr_data_reg;
  logic [7:0]    wr_data_next;
  logic [31:0]   pace_cnt_reg;
  logic [31:0]   pace_cnt_next;
  logic [1:0]    cmd_cnt_reg;
  logic [1:0]    cmd_cnt_next;
  logic          pace_viol_reg;
  logic          pace_viol_next;
  logic          cmd_taken;

  line_sync #(
    .WIDTH    (2)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .level    (lvl),
    .rise     (rise),
    .fall     (fall)
  );

  bus_low_watchdog #(
    .TIMEOUT_CYCLES (BUS_TIMEOUT),
    .SETTLE_CYCLES  (RELEASE_SETTLE)
  ) u_watchdog (
    .clk            (clk),
    .rst            (rst),
    .scl            (lvl[1]),
    .sda            (lvl[0]),
    .timeout        (bus_timeout),
    .sleep          (light_low_power)
  );

  assign scl_hi    = lvl[1];
  assign start_det = fall[0] & scl_hi;
  assign stop_det  = rise[0] & scl_hi;
  assign low_power = light_low_power | deep_low_power_mode;

  always_comb
  begin
    state_next       = state_reg;
    bit_cnt_next     = bit_cnt_reg;
    shift_next       = shift_reg;
    ptr_next         = ptr_reg;
    acked_next       = acked_reg;
    sda_drv_next     = sda_drv_reg;
    scl_drv_next     = scl_drv_reg;
    wake_next        = wake_reg;
    stretch_cnt_next = stretch_cnt_reg;
    wr_strobe_next   = 1'b0;
    wr_addr_next     = wr_addr_reg;
    wr_data_next     = wr_data_reg;
    cmd_taken        = 1'b0;

    if (bus_timeout)
    begin
      state_next   = ST_IDLE;
      sda_drv_next = 1'b0;
      scl_drv_next = 1'b0;
    end
    else if (scl_drv_reg)
    begin
      stretch_cnt_next = stretch_cnt_reg + 32'h0000_0001;
      if (wake_reg)
      begin
        if (stretch_cnt_reg == 32'(WAKE_STRETCH_CYCLES - 1))
          scl_drv_next = 1'b0;
      end
      else if (!flow_hold ||
               stretch_cnt_reg == 32'(FLOW_STRETCH - 1))
        scl_drv_next = 1'b0;
    end
    else if (start_det)
    begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      sda_drv_next = 1'b0;
    end
    else if (stop_det)
    begin
      state_next   = ST_IDLE;
      sda_drv_next = 1'b0;
    end
    else if (state_reg != ST_IDLE && rise[1])
    begin
      bit_cnt_next = bit_cnt_reg + 4'h1;
      if (state_reg != ST_READ && bit_cnt_reg < BIT_ACK)
        shift_next = {shift_reg[6:0], lvl[0]};
      else if (state_reg == ST_READ && bit_cnt_reg == BIT_ACK)
      begin
        acked_next = ~lvl[0];
        if (!lvl[0])
          ptr_next = ptr_reg + 8'h01;
      end
    end
    else if (state_reg != ST_IDLE && fall[1])
    begin
      unique case (state_reg)
        ST_ADDR, ST_CMD, ST_WRITE:
        begin
          if (bit_cnt_reg == BIT_ACK)
          begin
            acked_next = 1'b0;
            unique case (state_reg)
              ST_ADDR:
                acked_next = (shift_reg == ADDR_BYTE_WR) ||
                             (shift_reg == ADDR_BYTE_RD);
              ST_CMD:
              begin
                if (shift_reg <= CMD_LAST)
                begin
                  acked_next = 1'b1;
                  cmd_taken  = 1'b1;
                  ptr_next   = shift_reg;
                end
              end
              default:
              begin
                if (loc_writable(ptr_reg))
                begin
                  acked_next     = 1'b1;
                  wr_strobe_next = 1'b1;
                  wr_addr_next   = ptr_reg;
                  wr_data_next   = shift_reg;
                  ptr_next       = ptr_reg + 8'h01;
                end
              end
            endcase
            sda_drv_next = acked_next;
          end
          else if (bit_cnt_reg == BIT_DONE)
          begin
            sda_drv_next = 1'b0;
            bit_cnt_next = 4'h0;
            if (!acked_reg)
              state_next = ST_IDLE;
            else if (state_reg == ST_ADDR && shift_reg[0])
            begin
              state_next   = ST_READ;
              shift_next   = rd_data;
              sda_drv_next = ~rd_data[7];
            end
            else if (state_reg == ST_ADDR)
              state_next = ST_CMD;
            else
              state_next = ST_WRITE;
            if (acked_reg)
            begin
              scl_drv_next     = (state_reg == ST_ADDR && low_power) ||
                                 flow_hold;
              wake_next        = state_reg == ST_ADDR && low_power;
              stretch_cnt_next = 32'h0000_0000;
            end
          end
        end
        ST_READ:
        begin
          if (bit_cnt_reg < BIT_ACK)
          begin
            shift_next   = {shift_reg[6:0], 1'b0};
            sda_drv_next = ~shift_reg[6];
          end
          else if (bit_cnt_reg == BIT_ACK)
            sda_drv_next = 1'b0;
          else if (acked_reg)
          begin
            bit_cnt_next     = 4'h0;
            shift_next       = rd_data;
            sda_drv_next     = ~rd_data[7];
            scl_drv_next     = flow_hold;
            wake_next        = 1'b0;
            stretch_cnt_next = 32'h0000_0000;
          end
          else
            state_next = ST_IDLE;
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg       <= ST_IDLE;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      ptr_reg         <= PTR_RESET;
      acked_reg       <= 1'b0;
      sda_drv_reg     <= 1'b0;
      scl_drv_reg     <= 1'b0;
      wake_reg        <= 1'b0;
      stretch_cnt_reg <= 32'h0000_0000;
      wr_strobe_reg   <= 1'b0;
      wr_addr_reg     <= 8'h00;
      wr_data_reg     <= 8'h00;
    end
    else
    begin
      state_reg       <= state_next;
      bit_cnt_reg     <= bit_cnt_next;
      shift_reg       <= shift_next;
      ptr_reg         <= ptr_next;
      acked_reg       <= acked_next;
      sda_drv_reg     <= sda_drv_next;
      scl_drv_reg     <= scl_drv_next;
      wake_reg        <= wake_next;
      stretch_cnt_reg <= stretch_cnt_next;
      wr_strobe_reg   <= wr_strobe_next;
      wr_addr_reg     <= wr_addr_next;
      wr_data_reg     <= wr_data_next;
    end
  end

  // command pacing: the gauge cannot refuse, so it only flags overruns
  always_comb
  begin
    pace_cnt_next  = pace_cnt_reg + 32'h0000_0001;
    cmd_cnt_next   = cmd_cnt_reg;
    pace_viol_next = 1'b0;
    if (pace_cnt_reg == 32'(PACE_WINDOW - 1))
    begin
      pace_cnt_next = 32'h0000_0000;
      cmd_cnt_next  = cmd_taken ? 2'h1 : 2'h0;
    end
    else if (cmd_taken)
    begin
      if (cmd_cnt_reg == 2'(PACE_MAX_CMDS))
        pace_viol_next = 1'b1;
      else
        cmd_cnt_next = cmd_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pace_cnt_reg  <= 32'h0000_0000;
      cmd_cnt_reg   <= 2'h0;
      pace_viol_reg <= 1'b0;
    end
    else
    begin
      pace_cnt_reg  <= pace_cnt_next;
      cmd_cnt_reg   <= cmd_cnt_next;
      pace_viol_reg <= pace_viol_next;
    end
  end

  // pins are open drain: only ever pull low
  assign scl_out        = 1'b0;
  assign sda_out        = 1'b0;
  assign scl_oe_n       = ~scl_drv_reg;
  assign sda_oe_n       = ~sda_drv_reg;
  assign cmd_ptr        = ptr_reg;
  assign wr_strobe      = wr_strobe_reg;
  assign wr_addr        = wr_addr_reg;
  assign wr_data        = wr_data_reg;
  assign pace_violation = pace_viol_reg;

endmodule

`default_nettype wire

// file: gauge_i2c_pkg.sv
package gauge_i2c_pkg;

  // bus addressing
  localparam logic [6:0] TARGET_ADDR    = 7'h55;
  localparam logic [7:0] ADDR_BYTE_WR   = 8'hAA;
  localparam logic [7:0] ADDR_BYTE_RD   = 8'hAB;

  // command space
  localparam logic [7:0] CMD_LAST       = 8'h6B;
  localparam logic [7:0] CTRL_LO        = 8'h00;
  localparam logic [7:0] TEMP_HI        = 8'h03;
  localparam logic [7:0] DATA_CLASS     = 8'h3E;
  localparam logic [7:0] BLOCK_CTRL     = 8'h61;
  localparam logic [7:0] PTR_RESET      = 8'h00;

  // bit positions within a byte transfer
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [3:0] BIT_DONE       = 4'h9;

  // timing
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned BUS_TIMEOUT_MS    = 2000;
  localparam int unsigned WAKE_STRETCH_US   = 100;
  localparam int unsigned FLOW_STRETCH_MS   = 4;
  localparam int unsigned PACE_WINDOW_MS    = 1000;
  localparam int unsigned PACE_MAX_CMDS     = 2;
  localparam int unsigned RELEASE_SETTLE    = 4;
  localparam int unsigned BUS_TIMEOUT_CYCLES =
    (CLK_HZ / 1000) * BUS_TIMEOUT_MS;
  localparam int unsigned WAKE_STRETCH_CYCLES =
    (CLK_HZ / 1_000_000) * WAKE_STRETCH_US;
  localparam int unsigned FLOW_STRETCH_CYCLES =
    (CLK_HZ / 1000) * FLOW_STRETCH_MS;
  localparam int unsigned PACE_WINDOW_CYCLES =
    (CLK_HZ / 1000) * PACE_WINDOW_MS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WRITE,
    ST_READ
  } target_state_t;

  // locations a controller may write; everything else is read-only
  function automatic logic loc_writable(input logic [7:0] loc);
    loc_writable = (loc <= TEMP_HI) ||
                   (loc >= DATA_CLASS && loc <= BLOCK_CTRL);
  endfunction

endpackage

// file: line_sync.sv
`timescale 1ns/10ps
`default_nettype none

module line_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous lines
  input  wire logic [WIDTH-1:0] async_in,
  // synchronised view
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] prev_next;

  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // idle bus is pulled high, so reset to ones to avoid a false edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
      prev_reg <= '1;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

// file: bus_low_watchdog.sv
`timescale 1ns/10ps
`default_nettype none

module bus_low_watchdog #(
  parameter int unsigned TIMEOUT_CYCLES = 40_000_000,
  parameter int unsigned SETTLE_CYCLES  = 4
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // synchronised line levels
  input  wire logic scl,
  input  wire logic sda,
  // results
  output logic      timeout,
  output logic      sleep
);

  logic [31:0] low_cnt_reg;
  logic [31:0] low_cnt_next;
  logic        fired_reg;
  logic        fired_next;
  logic [31:0] settle_cnt_reg;
  logic [31:0] settle_cnt_next;
  logic        sleep_reg;
  logic        sleep_next;
  logic        any_low;

  always_comb
  begin
    any_low         = ~scl | ~sda;
    low_cnt_next    = low_cnt_reg;
    fired_next      = fired_reg;
    settle_cnt_next = settle_cnt_reg;
    sleep_next      = sleep_reg;
    timeout         = 1'b0;
    if (!any_low)
    begin
      low_cnt_next    = 32'h0000_0000;
      fired_next      = 1'b0;
      settle_cnt_next = 32'h0000_0000;
      sleep_next      = 1'b0;
    end
    else if (!fired_reg)
    begin
      if (low_cnt_reg == 32'(TIMEOUT_CYCLES - 1))
      begin
        timeout    = 1'b1;
        fired_next = 1'b1;
      end
      else
        low_cnt_next = low_cnt_reg + 32'h0000_0001;
    end
    // still low after our release: someone else holds it
    else if (settle_cnt_reg == 32'(SETTLE_CYCLES))
      sleep_next = 1'b1;
    else
      settle_cnt_next = settle_cnt_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_cnt_reg    <= 32'h0000_0000;
      fired_reg      <= 1'b0;
      settle_cnt_reg <= 32'h0000_0000;
      sleep_reg      <= 1'b0;
    end
    else
    begin
      low_cnt_reg    <= low_cnt_next;
      fired_reg      <= fired_next;
      settle_cnt_reg <= settle_cnt_next;
      sleep_reg      <= sleep_next;
    end
  end

  assign sleep = sleep_reg;

endmodule

`default_nettype wire

// file: gauge_i2c_target_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module gauge_i2c_target_asserts
  import gauge_i2c_pkg::*;
#(
  parameter int unsigned BUS_TIMEOUT  = 2000,
  parameter int unsigned FLOW_STRETCH = 200,
  parameter int unsigned PACE_WINDOW  = 1000
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // bus pins
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  // command space
  input wire logic [7:0] cmd_ptr,
  input wire logic [7:0] rd_data,
  input wire logic       wr_strobe,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // power and pacing
  input wire logic       flow_hold,
  input wire logic       deep_low_power_mode,
  input wire logic       light_low_power,
  input wire logic       pace_violation
);
  localparam int unsigned SMAX = (FLOW_STRETCH > WAKE_STRETCH_CYCLES) ?
    FLOW_STRETCH : WAKE_STRETCH_CYCLES;

  int unsigned st_reg;
  int unsigned st_next;
  int unsigned low_reg;
  int unsigned low_next;

  // run lengths of our own stretch and of any low line on the pins
  always_comb
  begin
    st_next  = scl_oe_n ? 32'd0 : st_reg + 32'd1;
    low_next = (scl_in && sda_in) ? 32'd0 : low_reg + 32'd1;
  end

  always_ff @(posedge clk)
  begin
    st_reg  <= rst ? 32'd0 : st_next;
    low_reg <= rst ? 32'd0 : low_next;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_strobe_pulse: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  a_ptr_step: assert property (
    wr_strobe |-> ##[0:1] cmd_ptr == wr_addr + 8'h01)
    else $error("pointer did not step past written location");
  a_write_allowed: assert property (wr_strobe |->
    (wr_addr <= 8'h03 || (wr_addr >= 8'h3E && wr_addr <= 8'h61)))
    else $error("write strobe to read-only location");
  a_stretch_bound: assert property (st_reg <= SMAX + 2)
    else $error("clock stretch too long");
  a_long_stretch_mode: assert property (
    st_reg > FLOW_STRETCH + 2 |-> deep_low_power_mode || light_low_power)
    else $error("long stretch outside low-power mode");
  a_low_release: assert property (
    low_reg > BUS_TIMEOUT + 6 |-> scl_oe_n && sda_oe_n)
    else $error("lines not released after bus-low timeout");
  a_sleep_cause: assert property (
    $rose(light_low_power) |-> $past(low_reg, 4) + 8 >= BUS_TIMEOUT)
    else $error("light low power without long low bus");
  a_sda_when_low: assert property (
    $changed(sda_oe_n) |-> !$past(scl_in, 2))
    else $error("data line moved while clock high");

  c_write: cover property (wr_strobe);
  c_stretch: cover property ($fell(scl_oe_n));
  c_sleep: cover property ($rose(light_low_power));
endmodule

bind gauge_i2c_target gauge_i2c_target_asserts #(
  .BUS_TIMEOUT(BUS_TIMEOUT), .FLOW_STRETCH(FLOW_STRETCH),
  .PACE_WINDOW(PACE_WINDOW)
) chk (
  .clk(clk), .rst(rst), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .cmd_ptr(cmd_ptr), .rd_data(rd_data),
  .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
  .flow_hold(flow_hold), .deep_low_power_mode(deep_low_power_mode),
  .light_low_power(light_low_power), .pace_violation(pace_violation)
);

`default_nettype wire

// file: bus_controller_model.sv
`timescale 1ns/10ps
`default_nettype none

module bus_controller_model (
  // clock
  input  wire logic clk,
  // resolved lines
  input  wire logic scl_bus,
  input  wire logic sda_bus,
  // open-drain pulls, high pulls the line low
  output var logic  scl_pull,
  output var logic  sda_pull
);
  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // target may stretch; a stuck line is left to the bench watchdog
  // the short step lets the released line settle, keeping 400 ns bits
  task automatic scl_up();
    scl_pull = 1'b0;
    #1;
    while (scl_bus !== 1'b1)
      tick(1);
  endtask

  task automatic clock_bit(input logic v, output logic s);
    tick(1);
    sda_pull = ~v;
    tick(3);
    scl_up();
    tick(2);
    s = sda_bus;
    tick(2);
    scl_pull = 1'b1;
  endtask

  task automatic start();
    tick(1);
    sda_pull = 1'b0;
    tick(3);
    scl_up();
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl_pull = 1'b1;
  endtask

  task automatic stop();
    tick(1);
    sda_pull = 1'b1;
    tick(3);
    scl_up();
    tick(4);
    sda_pull = 1'b0;
    tick(1320);
  endtask

  task automatic free();
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    tick(1320);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(1'b1, d[i]);
    clock_bit(~ack, s);
  endtask
endmodule

`default_nettype wire

// file: tb_gauge_i2c_target.sv
`timescale 1ns/10ps
`default_nettype none

module tb_gauge_i2c_target;
  import gauge_i2c_pkg::*;

  localparam int unsigned TOUT = 5000;
  localparam int unsigned FLOW = 200;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        flow_hold = 1'b0;
  logic        deep_low_power_mode = 1'b0;
  logic        scl_pull, sda_pull, scl_oe_n, sda_oe_n, scl_out, sda_out;
  logic        wr_strobe, light_low_power, pace_violation;
  logic [7:0]  cmd_ptr, wr_addr, wr_data;
  logic [7:0]  mem [256];
  logic [7:0]  bad [4] = '{8'hA8, 8'hAC, 8'h54, 8'h2B};
  logic [15:0] exp_wr [$];
  logic [15:0] exp_w;
  int          ptr, run, max_run, pace_cnt, cmds, error_cnt, total_checks;
  wire logic   scl_bus = ~scl_pull & (scl_oe_n | scl_out);
  wire logic   sda_bus = ~sda_pull & (sda_oe_n | sda_out);
  wire logic [7:0] rd_data = mem[cmd_ptr];

  always #25 clk = ~clk;

  // one pacing window spans the run: every command past the second flags
  gauge_i2c_target #(.BUS_TIMEOUT(TOUT), .FLOW_STRETCH(FLOW),
    .PACE_WINDOW(100000)) dut (
    .clk(clk), .rst(rst), .scl_in(scl_bus), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .cmd_ptr(cmd_ptr), .rd_data(rd_data),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .flow_hold(flow_hold), .deep_low_power_mode(deep_low_power_mode),
    .light_low_power(light_low_power), .pace_violation(pace_violation));

  bus_controller_model host (.clk(clk), .scl_bus(scl_bus),
    .sda_bus(sda_bus), .scl_pull(scl_pull), .sda_pull(sda_pull));

  task automatic tally(input logic ok, input string what);
    total_checks++;
    if (!ok)
    begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tally(g === e, $sformatf("flag %b expected %b", g, e));
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tally(g === e, $sformatf("byte %h expected %h", g, e));
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    tally(g === e, $sformatf("write %h expected %h", g, e));
  endtask

  task automatic done(input string name);
    $display("%s finished, mismatches %0d", name, error_cnt);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic writable(input int a);
    return a <= 8'h03 || (a >= 8'h3E && a <= 8'h61);
  endfunction

  always @(posedge clk)
  begin
    run = (scl_oe_n === 1'b0) ? run + 1 : 0;
    if (run > max_run)
      max_run = run;
    if (pace_violation === 1'b1)
      pace_cnt++;
    if (wr_strobe === 1'b1)
    begin
      exp_w = exp_wr.size() ? exp_wr.pop_front() : ~{wr_addr, wr_data};
      chk_word({wr_addr, wr_data}, exp_w);
    end
  end

  task automatic wr_xfer(input logic [7:0] cmd, input int n);
    logic       a;
    logic       ok;
    logic [7:0] d;
    host.start();
    host.put_byte(8'hAA, a);
    chk_bit(a, 1'b1);
    host.put_byte(cmd, a);
    ok = cmd <= 8'h6B;
    chk_bit(a, ok);
    if (ok)
      ptr = cmd;
    cmds += int'(ok);
    for (int i = 0; i < n && ok; i++)
    begin
      d  = 8'($urandom);
      ok = writable(ptr);
      if (ok)
        exp_wr.push_back({8'(ptr), d});
      host.put_byte(d, a);
      chk_bit(a, ok);
      if (ok)
        ptr = (ptr + 1) % 256;
    end
    host.stop();
    chk_byte(cmd_ptr, 8'(ptr));
  endtask

  task automatic rd_xfer(input logic quick, input logic [7:0] cmd,
                         input int n);
    logic       a;
    logic [7:0] d;
    if (!quick)
    begin
      host.start();
      host.put_byte(8'hAA, a);
      host.put_byte(cmd, a);
      chk_bit(a, 1'b1);
      ptr = cmd;
      cmds++;
    end
    host.start();
    host.put_byte(8'hAB, a);
    chk_bit(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      host.get_byte(i < n - 1, d);
      chk_byte(d, mem[ptr]);
      if (i < n - 1)
        ptr = (ptr + 1) % 256;
    end
    host.stop();
    chk_byte(cmd_ptr, 8'(ptr));
  endtask

  initial
  begin
    repeat (90000) @(posedge clk);
    tally(1'b0, "watchdog expired");
    finish_test();
  end

  initial
  begin
    logic a;
    void'($urandom(32'h7fa9));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    // subcommand sent as two one-byte packets
    // its result is never read back, so no wait is owed
    wr_xfer(8'h00, 1);
    wr_xfer(8'h01, 1);
    // crosses the end of the writable block, last byte refused
    wr_xfer(8'h60, 3);
    wr_xfer(8'h04, 1);
    done("writes");
    for (int i = 0; i < 3; i++)
      rd_xfer(1'b0, 8'($urandom_range(8'h6B, 8'h04)), 2 + i);
    rd_xfer(1'b0, 8'h6B, 1);
    rd_xfer(1'b1, 8'h00, 2);
    wr_xfer(8'h6C, 0);
    wr_xfer(8'hFF, 0);
    foreach (bad[i])
    begin
      host.start();
      host.put_byte(bad[i], a);
      chk_bit(a, 1'b0);
      host.stop();
    end
    done("reads and refusals");
    deep_low_power_mode = 1'b1;
    max_run = 0;
    wr_xfer(8'h02, 1);
    chk_bit(max_run > 0 && max_run <= WAKE_STRETCH_CYCLES, 1'b1);
    deep_low_power_mode = 1'b0;
    flow_hold = 1'b1;
    max_run = 0;
    wr_xfer(8'h03, 1);
    flow_hold = 1'b0;
    chk_bit(max_run > 0 && max_run <= FLOW, 1'b1);
    done("stretch");
    // controller stalls with the clock held low mid-read
    mem[ptr] = 8'h00;
    host.start();
    host.put_byte(8'hAB, a);
    repeat (TOUT + 40) @(negedge clk);
    chk_bit(scl_oe_n & sda_oe_n, 1'b1);
    chk_bit(light_low_power, 1'b1);
    host.free();
    chk_bit(light_low_power, 1'b0);
    rd_xfer(1'b1, 8'h00, 1);
    done("timeout");
    chk_byte(8'(pace_cnt), 8'(cmds > 2 ? cmds - 2 : 0));
    chk_byte(8'(exp_wr.size()), 8'h00);
    finish_test();
  end
endmodule

`default_nettype wire
